// *** rtl/hrs_top.sv ***
// Host read source multiplexer of the byte-wide microprocessor port.
`timescale 1ns/1ps
module hrs_top
    import hrs_pkg::*;
(
    input wire logic clk,                  // 50 MHz clock.
    input wire logic arst_n,               // Asynchronous reset, active low.
    input wire logic wr_n,                 // Host write strobe pin, active low.
    input wire logic rd_n,                 // Host read strobe pin, active low.
    input wire logic [2:0] addr,           // Host address pins.
    input wire logic [7:0] data_in,        // Host data bus, input side.
    output logic [7:0] data_out,           // Host data bus, output side.
    output logic data_oe_n,                // Data bus output enable, low while driving.
    input wire logic [7:0] dest_addr,      // Destination address held by the write section.
    input wire logic dest_load,            // One-cycle pulse: destination register loaded.
    input wire logic [15:0] i_sample,      // Buffered I sample.
    input wire logic [15:0] q_sample,      // Buffered Q sample.
    input wire logic [15:0] mag_sample,    // Buffered magnitude.
    input wire logic [15:0] phase_sample,  // Buffered phase.
    input wire logic [15:0] freq_sample,   // Buffered frequency.
    input wire logic [23:0] level_result,  // Input level detector result.
    input wire logic [10:0] gain_mantissa, // Live linear gain mantissa.
    input wire logic [3:0] gain_shift,     // Live gain shift control.
    input wire logic [15:0] timing_error,  // Live timing error.
    input wire logic [2:0] fifo_depth,     // FIFO fill depth.
    input wire logic fifo_mode,            // High while buffer runs as FIFO.
    input wire logic fifo_empty,           // FIFO empty, active high.
    input wire logic fifo_full,            // FIFO full, active high.
    input wire logic buffer_ready_n,       // Buffer threshold or snapshot count reached, active low.
    input wire logic level_done            // Level integration complete, active high.
);
    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic [12:0] pins_s;
    // Each strobe phase must last three clocks or more for its edges to be seen.
    hrs_sync #(.WIDTH(13)) u_sync (
        .clk(clk),
        .arst_n(arst_n),
        .d({~wr_n, ~rd_n, addr, data_in}),
        .q(pins_s)
    );
    logic wr_n_s;
    logic rd_n_s;
    logic [2:0] addr_s;
    logic [7:0] data_s;
    // Strobes enter the synchroniser inverted, so its cleared state reads as idle.
    assign wr_n_s = ~pins_s[12];
    assign rd_n_s = ~pins_s[11];
    assign addr_s = pins_s[10:8];
    assign data_s = pins_s[7:0];

    // ----------------------------------------------------------------
    // Strobe edge detection
    // ----------------------------------------------------------------
    logic wr_n_d_ff;
    logic rd_n_d_ff;
    logic [2:0] wr_addr_ff;
    logic [7:0] wr_data_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_n_d_ff <= 1'b1;
            rd_n_d_ff <= 1'b1;
            wr_addr_ff <= 3'h0;
            wr_data_ff <= 8'h00;
        end else begin
            wr_n_d_ff <= wr_n_s;
            rd_n_d_ff <= rd_n_s;
            if (!wr_n_s) begin
                wr_addr_ff <= addr_s;
                wr_data_ff <= data_s;
            end
        end
    end
    logic wr_rise;
    logic rd_fall;
    assign wr_rise = wr_n_s & ~wr_n_d_ff;
    assign rd_fall = ~rd_n_s & rd_n_d_ff;

    // ----------------------------------------------------------------
    // Read source select
    // ----------------------------------------------------------------
    hrs_src_e src_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            src_ff <= hrs_src_e'(HRS_CODE_RESET);
        end else if (wr_rise && wr_addr_ff == HRS_ADDR_SRC_SEL) begin
            src_ff <= hrs_src_e'(wr_data_ff[2:0]);
        end
    end

    // ----------------------------------------------------------------
    // Gain sample
    // ----------------------------------------------------------------
    logic [10:0] gain_man_ff;
    logic [3:0] gain_shift_ff;
    // Readout shows the gain held at the last load of location 10, never the live value.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gain_man_ff <= 11'h000;
            gain_shift_ff <= 4'h0;
        end else if (dest_load && dest_addr == HRS_GAIN_SAMPLE_DEST) begin
            gain_man_ff <= gain_mantissa;
            gain_shift_ff <= gain_shift;
        end
    end

    // ----------------------------------------------------------------
    // Byte selection
    // ----------------------------------------------------------------
    function automatic logic [7:0] pick16(input logic [15:0] w, input logic hi);
        pick16 = hi ? w[15:8] : w[7:0];
    endfunction : pick16

    logic [HRS_STATUS_W-1:0] status;
    always_comb begin
        status = {(fifo_mode ? fifo_depth : {HRS_DEPTH_W{1'b0}}),
                  fifo_empty,
                  fifo_full,
                  buffer_ready_n,
                  level_done};
    end

    logic [7:0] sel_byte;
    always_comb begin
        sel_byte = HRS_BYTE_ZERO;
        if (addr_s == HRS_ADDR_STATUS) begin
            sel_byte = {1'b0, status};
        end else begin
            case (src_ff)
                HRS_SRC_IQ: begin
                    if (addr_s == HRS_ADDR_B0 || addr_s == HRS_ADDR_B1) begin
                        sel_byte = pick16(i_sample, addr_s[0]);
                    end else if (addr_s == HRS_ADDR_B2 || addr_s == HRS_ADDR_B3) begin
                        sel_byte = pick16(q_sample, addr_s[0]);
                    end
                end
                HRS_SRC_MAGPH: begin
                    if (addr_s == HRS_ADDR_B0 || addr_s == HRS_ADDR_B1) begin
                        sel_byte = pick16(mag_sample, addr_s[0]);
                    end else if (addr_s == HRS_ADDR_B2 || addr_s == HRS_ADDR_B3) begin
                        sel_byte = pick16(phase_sample, addr_s[0]);
                    end
                end
                HRS_SRC_FREQ: begin
                    if (addr_s == HRS_ADDR_B0 || addr_s == HRS_ADDR_B1) begin
                        sel_byte = pick16(freq_sample, addr_s[0]);
                    end
                end
                HRS_SRC_LEVEL: begin
                    if (addr_s == HRS_ADDR_B0) begin
                        sel_byte = level_result[7:0];
                    end else if (addr_s == HRS_ADDR_B1) begin
                        sel_byte = level_result[15:8];
                    end else if (addr_s == HRS_ADDR_B2) begin
                        sel_byte = level_result[23:16];
                    end
                end
                HRS_SRC_AGC_TE: begin
                    if (addr_s == HRS_ADDR_B0) begin
                        sel_byte = gain_man_ff[7:0];
                    end else if (addr_s == HRS_ADDR_B1) begin
                        sel_byte = {1'b0, gain_shift_ff, gain_man_ff[10:8]};
                    end else if (addr_s == HRS_ADDR_B2 || addr_s == HRS_ADDR_B3) begin
                        sel_byte = pick16(timing_error, addr_s[0]);
                    end
                end
                default: begin
                    sel_byte = HRS_BYTE_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data bus drive
    // ----------------------------------------------------------------
    // The byte follows the address while the strobe stays low, so the host may
    // change address between strobes as well as within one.
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            data_out <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            data_oe_n <= rd_n_s;
            data_out <= rd_n_s ? HRS_BYTE_ZERO : sel_byte;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_bus_release: assert property (@(posedge clk) disable iff (!arst_n)
        rd_n_s |=> data_oe_n) else $error("bus driven while read strobe high");
    chk_drive_on_fall: assert property (@(posedge clk) disable iff (!arst_n)
        rd_fall |=> !data_oe_n) else $error("bus not driven after read strobe fall");
    chk_status_any_code: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS) |=> data_out == {1'b0, $past(status)})
        else $error("status byte wrong");
    chk_code_latch: assert property (@(posedge clk) disable iff (!arst_n)
        (wr_rise && wr_addr_ff == HRS_ADDR_SRC_SEL) |=> src_ff == $past(wr_data_ff[2:0]))
        else $error("read code not latched");
    chk_code_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !(wr_rise && wr_addr_ff == HRS_ADDR_SRC_SEL) |=> $stable(src_ff))
        else $error("read code changed without write");
    chk_gain_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !(dest_load && dest_addr == HRS_GAIN_SAMPLE_DEST) |=> $stable(gain_man_ff))
        else $error("gain sample moved without write");
    chk_level_msb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_LEVEL && addr_s == HRS_ADDR_B2) |=> data_out == $past(level_result[23:16]))
        else $error("level msb wrong");
    chk_unused_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_UNUSED3 && addr_s != HRS_ADDR_STATUS) |=> data_out == HRS_BYTE_ZERO)
        else $error("unused code not zero");
    chk_depth_gate: assert property (@(posedge clk) disable iff (!arst_n)
        !fifo_mode |-> status[6:4] == 3'h0) else $error("depth shown outside fifo mode");

    // ----------------------------------------------------------------
    // Data path checks
    // ----------------------------------------------------------------
    chk_iq_q_msb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_IQ && addr_s == HRS_ADDR_B3)
        |=> data_out == $past(q_sample[15:8]))
        else $error("q msb wrong");
    chk_magph_lsb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_MAGPH && addr_s == HRS_ADDR_B0)
        |=> data_out == $past(mag_sample[7:0]))
        else $error("magnitude lsb wrong");
    chk_phase_msb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_MAGPH && addr_s == HRS_ADDR_B3)
        |=> data_out == $past(phase_sample[15:8]))
        else $error("phase msb wrong");
    chk_freq_msb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_FREQ && addr_s == HRS_ADDR_B1)
        |=> data_out == $past(freq_sample[15:8]))
        else $error("frequency msb wrong");
    chk_freq_gap_zero: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_FREQ && addr_s == HRS_ADDR_B2)
        |=> data_out == HRS_BYTE_ZERO)
        else $error("unmapped frequency byte not zero");
    chk_level_lsb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_LEVEL && addr_s == HRS_ADDR_B0)
        |=> data_out == $past(level_result[7:0]))
        else $error("level lsb wrong");
    chk_level_mid: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_LEVEL && addr_s == HRS_ADDR_B1)
        |=> data_out == $past(level_result[15:8]))
        else $error("level middle byte wrong");
    chk_gain_capture: assert property (@(posedge clk) disable iff (!arst_n)
        (dest_load && dest_addr == HRS_GAIN_SAMPLE_DEST)
        |=> gain_man_ff == $past(gain_mantissa) && gain_shift_ff == $past(gain_shift))
        else $error("gain not captured");
    chk_gain_low: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_AGC_TE && addr_s == HRS_ADDR_B0)
        |=> data_out == $past(gain_man_ff[7:0]))
        else $error("gain low byte wrong");
    chk_gain_high: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_AGC_TE && addr_s == HRS_ADDR_B1)
        |=> data_out == {1'b0, $past(gain_shift_ff), $past(gain_man_ff[10:8])})
        else $error("gain high byte wrong");
    chk_te_lsb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_AGC_TE && addr_s == HRS_ADDR_B2)
        |=> data_out == $past(timing_error[7:0]))
        else $error("timing error lsb wrong");
    chk_te_msb: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_AGC_TE && addr_s == HRS_ADDR_B3)
        |=> data_out == $past(timing_error[15:8]))
        else $error("timing error msb wrong");
    chk_depth_shown: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS && fifo_mode)
        |=> data_out[6:4] == $past(fifo_depth))
        else $error("fifo depth not shown");
    chk_empty_flag: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS)
        |=> data_out[3] == $past(fifo_empty))
        else $error("empty flag wrong");
    chk_full_flag: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS)
        |=> data_out[2] == $past(fifo_full))
        else $error("full flag wrong");
    chk_ready_flag: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS)
        |=> data_out[1] == $past(buffer_ready_n))
        else $error("ready flag wrong");
    chk_done_flag: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && addr_s == HRS_ADDR_STATUS)
        |=> data_out[0] == $past(level_done))
        else $error("integration flag wrong");
    chk_bus_zero_idle: assert property (@(posedge clk) disable iff (!arst_n)
        rd_n_s
        |=> data_out == HRS_BYTE_ZERO)
        else $error("data not zero while bus released");
    chk_unused_six: assert property (@(posedge clk) disable iff (!arst_n)
        (!rd_n_s && src_ff == HRS_SRC_UNUSED6 && addr_s != HRS_ADDR_STATUS)
        |=> data_out == HRS_BYTE_ZERO)
        else $error("unused code six not zero");
    cov_status_read: cover property (@(posedge clk) disable iff (!arst_n)
        rd_fall && addr_s == HRS_ADDR_STATUS);
    cov_level_read: cover property (@(posedge clk) disable iff (!arst_n)
        rd_fall && src_ff == HRS_SRC_LEVEL);
    cov_gain_sample: cover property (@(posedge clk) disable iff (!arst_n)
        dest_load && dest_addr == HRS_GAIN_SAMPLE_DEST);
    cov_agc_read: cover property (@(posedge clk) disable iff (!arst_n)
        rd_fall && src_ff == HRS_SRC_AGC_TE);
    cov_code_write: cover property (@(posedge clk) disable iff (!arst_n)
        wr_rise && wr_addr_ff == HRS_ADDR_SRC_SEL);
endmodule : hrs_top

// *** pkg/hrs_pkg.sv ***
// Constants and types of the host read source multiplexer.
// Contract
// - Host writes read code at address 5; latched at write strobe rising edge.
// - Codes 000/001/010 give I/Q, magnitude/phase, frequency bytes LSB first.
// - Code 100 gives level detector bits 0-7, 8-15, 16-23 at 000-010.
// - Code 101 gain is sampled by a write to location 10, not live.
// - Code 101 address 000 low mantissa, 001 shift bits plus top mantissa.
// - Code 101 addresses 010/011 give timing error bytes, not stabilised.
// - Address 111 returns the 7-bit status byte whatever the read code.
// - Status bits 6 to 4 show FIFO depth in FIFO mode.
// - Status bit 3 high when FIFO is empty.
// - Status bit 2 high when FIFO is full; new samples discarded.
// - Status bit 1 low when threshold reached or snapshot count taken.
// - Status bit 0 high when level integration completed and ready.
// - Read source is the lower three bits of the byte written to address 5.
// - Selected byte driven on data bus from the read strobe falling edge.
package hrs_pkg;
    localparam logic [2:0] HRS_ADDR_SRC_SEL = 3'h5;
    localparam logic [2:0] HRS_ADDR_STATUS = 3'h7;
    localparam logic [2:0] HRS_ADDR_B0 = 3'h0;
    localparam logic [2:0] HRS_ADDR_B1 = 3'h1;
    localparam logic [2:0] HRS_ADDR_B2 = 3'h2;
    localparam logic [2:0] HRS_ADDR_B3 = 3'h3;
    localparam logic [7:0] HRS_GAIN_SAMPLE_DEST = 8'h0a;
    localparam logic [2:0] HRS_CODE_RESET = 3'h0;
    localparam logic [7:0] HRS_BYTE_ZERO = 8'h00;
    localparam int HRS_STATUS_W = 7;
    localparam int HRS_DEPTH_W = 3;
    typedef enum logic [2:0] {
        HRS_SRC_IQ = 3'h0,
        HRS_SRC_MAGPH = 3'h1,
        HRS_SRC_FREQ = 3'h2,
        HRS_SRC_UNUSED3 = 3'h3,
        HRS_SRC_LEVEL = 3'h4,
        HRS_SRC_AGC_TE = 3'h5,
        HRS_SRC_UNUSED6 = 3'h6,
        HRS_SRC_UNUSED7 = 3'h7
    } hrs_src_e;
endpackage : hrs_pkg

// *** rtl/hrs_sync.sv ***
// Two flip-flop synchroniser for asynchronous input bits.
`timescale 1ns/1ps
module hrs_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,               // System clock.
    input wire logic arst_n,            // Asynchronous reset, active low.
    input wire logic [WIDTH-1:0] d,     // Asynchronous input.
    output logic [WIDTH-1:0] q          // Synchronised output.
);
    logic [WIDTH-1:0] meta_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q <= '0;
        end else begin
            meta_ff <= d;
            q <= meta_ff;
        end
    end
endmodule : hrs_sync

// *** tb/hrs_host_model.sv ***
// Host microprocessor model driving the byte-wide port strobes.
`timescale 1ns/1ps
module hrs_host_model (
    input wire logic clk,            // System clock.
    input wire logic [7:0] data_out, // Device data output.
    input wire logic data_oe_n,      // Device output enable, low while driving.
    output logic wr_n,               // Write strobe, active low.
    output logic rd_n,               // Read strobe, active low.
    output logic [2:0] addr,         // Address pins.
    output logic [7:0] data_in       // Data driven by the host.
);
    initial begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        addr = 3'h0;
        data_in = 8'h00;
    end
    // Each strobe phase lasts four cycles; released data shows the inverse byte.
    task automatic do_write(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        data_in <= d;
        wr_n <= 1'b0;
        repeat (4) @(posedge clk);
        wr_n <= 1'b1;
        repeat (4) @(posedge clk);
        data_in <= ~d;
    endtask : do_write
    task automatic do_read(input logic [2:0] a, output logic [7:0] d);
        int n;
        d = 8'hxx;
        @(posedge clk);
        addr <= a;
        rd_n <= 1'b0;
        for (n = 0; n < 8; n++) begin
            @(negedge clk);
            if (data_oe_n === 1'b0) begin
                d = data_out;
                break;
            end
        end
        @(posedge clk);
        rd_n <= 1'b1;
        for (n = 0; n < 8; n++) begin
            @(negedge clk);
            if (data_oe_n === 1'b1) break;
        end
        @(posedge clk);
    endtask : do_read
endmodule : hrs_host_model

// *** tb/host_read_source_mux_bench.sv ***
// Self-checking bench of the host read source multiplexer.
`timescale 1ns/1ps
module host_read_source_mux_bench;
    import hrs_pkg::*;
    typedef struct packed {
        logic [2:0] code;
        logic [2:0] addr;
        logic [7:0] exp;
    } hrs_row_s;
    logic clk, arst_n, wr_n, rd_n, data_oe_n, dest_load, fifo_mode, fifo_empty, fifo_full;
    logic buffer_ready_n, level_done;
    logic [2:0] addr, fifo_depth;
    logic [7:0] data_in, data_out, dest_addr;
    logic [15:0] i_sample, q_sample, mag_sample, phase_sample, freq_sample, timing_error;
    logic [23:0] level_result;
    logic [10:0] gain_mantissa;
    logic [3:0] gain_shift;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;
    hrs_row_s rows [23] = '{
        '{3'h0, 3'h0, 8'h34}, '{3'h0, 3'h1, 8'h12}, '{3'h0, 3'h2, 8'h78}, '{3'h0, 3'h3, 8'h56},
        '{3'h1, 3'h0, 8'hbc}, '{3'h1, 3'h1, 8'h9a}, '{3'h1, 3'h2, 8'hf0}, '{3'h1, 3'h3, 8'hde},
        '{3'h2, 3'h0, 8'h1e}, '{3'h2, 3'h1, 8'h0f}, '{3'h2, 3'h2, 8'h00}, '{3'h3, 3'h0, 8'h00},
        '{3'h4, 3'h0, 8'hf5}, '{3'h4, 3'h1, 8'h1a}, '{3'h4, 3'h2, 8'h32}, '{3'h4, 3'h3, 8'h00},
        '{3'h5, 3'h0, 8'ha3}, '{3'h5, 3'h1, 8'h4d}, '{3'h5, 3'h2, 8'hef}, '{3'h5, 3'h3, 8'hbe},
        '{3'h6, 3'h1, 8'h00}, '{3'h7, 3'h0, 8'h00}, '{3'h3, 3'h7, 8'h53}};
    hrs_top i_hrs_top (.clk(clk), .arst_n(arst_n), .wr_n(wr_n), .rd_n(rd_n), .addr(addr),
        .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n), .dest_addr(dest_addr),
        .dest_load(dest_load), .i_sample(i_sample), .q_sample(q_sample), .mag_sample(mag_sample),
        .phase_sample(phase_sample), .freq_sample(freq_sample), .level_result(level_result),
        .gain_mantissa(gain_mantissa), .gain_shift(gain_shift), .timing_error(timing_error),
        .fifo_depth(fifo_depth), .fifo_mode(fifo_mode), .fifo_empty(fifo_empty), .fifo_full(fifo_full),
        .buffer_ready_n(buffer_ready_n), .level_done(level_done));
    hrs_host_model i_hrs_host_model (.clk(clk), .data_out(data_out), .data_oe_n(data_oe_n),
        .wr_n(wr_n), .rd_n(rd_n), .addr(addr), .data_in(data_in));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic pulse_dest(input logic [7:0] da);
        @(posedge clk);
        dest_addr <= da;
        dest_load <= 1'b1;
        @(posedge clk);
        dest_load <= 1'b0;
    endtask : pulse_dest
    task automatic rd_check(input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] got;
        i_hrs_host_model.do_read(a, got);
        check(got, exp);
    endtask : rd_check
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            print_verdict();
        end
    end
    initial begin
        logic [2:0] cur;
        arst_n = 1'b0;
        dest_addr = 8'h00;
        dest_load = 1'b0;
        {i_sample, q_sample, mag_sample, phase_sample} = 64'h1234_5678_9abc_def0;
        freq_sample = 16'h0f1e;
        level_result = 24'h321af5;
        {gain_shift, gain_mantissa} = {4'h9, 11'h5a3};
        timing_error = 16'hbeef;
        {fifo_depth, fifo_mode, fifo_empty, fifo_full, buffer_ready_n, level_done} = 8'hb3;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        check({7'h00, data_oe_n}, 8'h01);
        check(data_out, 8'h00);
        rd_check(3'h0, 8'h34);
        pulse_dest(8'h0a);
        cur = 3'h0;
        foreach (rows[k]) begin
            if (rows[k].code !== cur) i_hrs_host_model.do_write(HRS_ADDR_SRC_SEL, {5'h1f, rows[k].code});
            cur = rows[k].code;
            rd_check(rows[k].addr, rows[k].exp);
        end
        // Gain readout must stay on the sampled value until location 10 is written.
        @(posedge clk);
        {gain_shift, gain_mantissa} <= 15'h0000;
        timing_error <= 16'h1357;
        i_hrs_host_model.do_write(HRS_ADDR_SRC_SEL, 8'h05);
        rd_check(3'h0, 8'ha3);
        pulse_dest(8'h0b);
        rd_check(3'h1, 8'h4d);
        pulse_dest(8'h0a);
        rd_check(3'h0, 8'h00);
        rd_check(3'h1, 8'h00);
        i_hrs_host_model.do_write(3'h4, 8'h00);
        rd_check(3'h2, 8'h57);
        rd_check(3'h3, 8'h13);
        @(posedge clk);
        {fifo_depth, fifo_mode, fifo_empty, fifo_full, buffer_ready_n, level_done} <= 8'hec;
        rd_check(3'h7, 8'h0c);
        check({7'h00, data_oe_n}, 8'h01);
        check(data_out, 8'h00);
        // A reset in mid-run must bring the read code back to 000.
        @(posedge clk);
        arst_n <= 1'b0;
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rd_check(3'h0, 8'h34);
        print_verdict();
    end
endmodule : host_read_source_mux_bench
